// File: ehpc_pkg.sv
// constants and carriers for the identification ram and hot plug block
package ehpc_pkg;
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned STEP_MS     = 100;
   localparam int unsigned STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
   localparam int unsigned CLEAR_MS    = 1;
   localparam int unsigned CLEAR_MAX_CYCLES = CLK_HZ / 1000 * CLEAR_MS;
   localparam int unsigned RAM_BYTES   = 512;
   localparam logic [6:0]  CKSUM_POS   = 7'h7F;
   localparam logic [8:0]  RAM_LAST    = 9'h1FF;

   localparam logic [8:0] OFS_HPD_PIN  = 9'h020;
   localparam logic [8:0] OFS_HPD_STAT = 9'h021;
   localparam logic [8:0] OFS_REBOOT   = 9'h05A;
   localparam logic [8:0] OFS_HPD_CTL  = 9'h06C;
   localparam logic [8:0] OFS_ID_EN    = 9'h074;
   localparam logic [8:0] OFS_ID_FLAG  = 9'h076;
   localparam logic [8:0] OFS_WAKE     = 9'h07A;

   localparam int BIT_MAN_A   = 7;
   localparam int BIT_MAN_B   = 6;
   localparam int BIT_FLOAT_A = 3;
   localparam int BIT_FLOAT_B = 2;
   localparam int BIT_DRV_A   = 3;
   localparam int BIT_DRV_B   = 2;
   localparam int BIT_REBOOT  = 3;
   localparam int BIT_DELAY   = 4;
   localparam int BIT_TERM    = 3;
   localparam int BIT_MODE    = 1;
   localparam int BIT_MANUAL  = 0;
   localparam int BIT_EN      = 0;
   localparam int BIT_NOAUTO  = 1;

   localparam logic [1:0] RST_MAN_LEVEL = 2'h3;
   localparam logic [3:0] RST_DELAY     = 4'hA;
   localparam logic [1:0] RST_MODE      = 2'h1;

   localparam logic [7:0] DDC_EDID_WR = 8'hA0;
   localparam logic [7:0] DDC_SEG_WR  = 8'h60;

   typedef enum logic [1:0] {
      EHPC_MAP_IO,
      EHPC_MAP_LINK,
      EHPC_MAP_REPT,
      EHPC_MAP_EDID
   } ehpc_map_t;

   typedef struct packed {
      logic       we;
      ehpc_map_t  map;
      logic [8:0] addr;
      logic [7:0] wdata;
   } ehpc_req_t;
endpackage

// File: ehpc_top.sv
// identification ram, checksum controller, ddc slaves and hot plug control
`timescale 1ns/1ns

module ehpc_ddc_slave (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       scl_pin,
   input  wire logic       sda_pin,
   input  wire logic       enabled,
   input  wire logic [7:0] rd_data,
   output logic      [8:0] rd_addr,
   output logic            sda_out,
   output logic            sda_oe
);
   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_RACK
   } ehpc_ddc_st_t;

   ehpc_ddc_st_t st_q;
   logic [1:0]   scl_s_q;
   logic [1:0]   sda_s_q;
   logic         scl_p_q;
   logic         sda_p_q;
   logic [2:0]   cnt_q;
   logic [7:0]   sh_q;
   logic [7:0]   rd_sh_q;
   logic [7:0]   ofs_q;
   logic [7:0]   seg_q;
   logic         is_rd_q;
   logic         is_seg_q;
   logic         low_q;
   logic         scl;
   logic         sda;
   logic         start;
   logic         stop;
   logic         rise;
   logic         fall;
   logic [7:0]   byte_in;

   assign scl     = scl_s_q[1];
   assign sda     = sda_s_q[1];
   assign start   = scl & scl_p_q & sda_p_q & ~sda;
   assign stop    = scl & scl_p_q & ~sda_p_q & sda;
   assign rise    = scl & ~scl_p_q;
   assign fall    = ~scl & scl_p_q;
   assign byte_in = {sh_q[6:0], sda};
   assign rd_addr = {seg_q[0], ofs_q};
   assign sda_out = 1'b0;
   assign sda_oe  = low_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_pin};
         sda_s_q <= {sda_s_q[0], sda_pin};
         scl_p_q <= scl;
         sda_p_q <= sda;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q     <= S_IDLE;
         cnt_q    <= 3'h0;
         sh_q     <= 8'h00;
         rd_sh_q  <= 8'h00;
         ofs_q    <= 8'h00;
         seg_q    <= 8'h00;
         is_rd_q  <= 1'b0;
         is_seg_q <= 1'b0;
      end else if (start) begin
         st_q  <= S_ADDR;
         cnt_q <= 3'h0;
      end else if (stop) begin
         st_q  <= S_IDLE;
         seg_q <= 8'h00;
      end else if (rise) begin
         case (st_q)
            S_ADDR: begin
               sh_q  <= byte_in;
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == 3'h7) begin
                  is_rd_q  <= byte_in[0];
                  is_seg_q <= byte_in == ehpc_pkg::DDC_SEG_WR;
                  // only the data address answers reads
                  st_q <= (enabled &&
                     (byte_in[7:1] == ehpc_pkg::DDC_EDID_WR[7:1] ||
                      byte_in == ehpc_pkg::DDC_SEG_WR)) ? S_AACK : S_IDLE;
               end
            end
            S_AACK: begin
               cnt_q <= 3'h0;
               if (is_rd_q) begin
                  rd_sh_q <= rd_data;
                  st_q    <= S_RD;
               end else begin
                  st_q <= S_WR;
               end
            end
            S_WR: begin
               sh_q  <= byte_in;
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == 3'h7) begin
                  if (is_seg_q) begin
                     seg_q <= byte_in;
                  end else begin
                     ofs_q <= byte_in;
                  end
                  st_q <= S_WACK;
               end
            end
            // data bytes after the offset are refused
            S_WACK: st_q <= S_IDLE;
            S_RD: begin
               rd_sh_q <= {rd_sh_q[6:0], 1'b0};
               cnt_q   <= cnt_q + 3'h1;
               if (cnt_q == 3'h7) begin
                  ofs_q <= ofs_q + 8'h01;
                  st_q  <= S_RACK;
               end
            end
            S_RACK: begin
               if (!sda) begin
                  rd_sh_q <= rd_data;
                  cnt_q   <= 3'h0;
                  st_q    <= S_RD;
               end else begin
                  st_q <= S_IDLE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         low_q <= 1'b0;
      end else if (start || stop) begin
         low_q <= 1'b0;
      end else if (fall) begin
         low_q <= st_q == S_AACK || st_q == S_WACK ||
                  (st_q == S_RD && !rd_sh_q[7]);
      end
   end
endmodule

module ehpc_top #(
   parameter int STEP_CYCLES = ehpc_pkg::STEP_CYCLES
) (
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               req_valid,
   input  wire ehpc_pkg::ehpc_req_t req,
   output logic                    rsp_valid_q,
   output logic [7:0]              rsp_data_q,
   input  wire logic               pd_mode0,
   input  wire logic [1:0]         cable_det,
   input  wire logic [1:0]         term_ctrl,
   output logic [1:0]              term_en,
   output logic [1:0]              hpd_out,
   output logic [1:0]              hpd_oe,
   input  wire logic [1:0]         ddc_scl,
   input  wire logic [1:0]         ddc_sda_in,
   output logic [1:0]              ddc_sda_out,
   output logic [1:0]              ddc_sda_oe,
   output logic                    key_vector_clear
);
   localparam int STEP_W = $clog2(STEP_CYCLES);
   typedef enum logic [1:0] {C_CLEAR, C_IDLE, C_SUM} ehpc_ctl_st_t;

   ehpc_ctl_st_t cst_q;
   logic [7:0]  ram [ehpc_pkg::RAM_BYTES];
   logic [1:0]  man_level_q, float_q, mode_q, en_q, en_p_q;
   logic [3:0]  delay_q;
   logic        term_ovr_q, manual_q, no_auto_q, reboot_q, pd_p_q;
   logic [8:0]  caddr_q;
   logic [7:0]  sum_q;
   logic [1:0]  pend_q, batch_q, act_q, hpa_q, status, hpa_d;
   logic [1:0]  cab_m_q, cab_q, dly_q;
   logic [STEP_W-1:0] step_q [2];
   logic [3:0]  tick_q [2];
   logic [8:0]  ddc_addr [2];
   logic        wr_io, wr_link, wr_rept, host_we, ctrl_we, wake, sweep_end;
   logic [7:0]  ctrl_wdata, rd_val;

   assign wr_io   = req_valid && req.we && req.map == ehpc_pkg::EHPC_MAP_IO;
   assign wr_link = req_valid && req.we &&
                    req.map == ehpc_pkg::EHPC_MAP_LINK;
   assign wr_rept = req_valid && req.we &&
                    req.map == ehpc_pkg::EHPC_MAP_REPT;
   // host ram writes only while the controller leaves the ram alone
   assign host_we = req_valid && req.we && cst_q == C_IDLE &&
                    req.map == ehpc_pkg::EHPC_MAP_EDID;
   assign wake    = pd_p_q && !pd_mode0 && !no_auto_q;
   assign sweep_end = cst_q == C_SUM && caddr_q == ehpc_pkg::RAM_LAST;
   assign ctrl_we = cst_q == C_CLEAR ||
      (cst_q == C_SUM && caddr_q[6:0] == ehpc_pkg::CKSUM_POS);
   assign ctrl_wdata = (cst_q == C_CLEAR) ? 8'h00 : 8'h00 - sum_q;
   assign key_vector_clear = cst_q == C_CLEAR;
   assign status  = hpa_q & ~float_q;
   assign hpd_out = hpa_q;
   assign hpd_oe  = ~float_q;
   assign term_en = term_ovr_q ? status : term_ctrl;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         man_level_q <= ehpc_pkg::RST_MAN_LEVEL;
         float_q     <= 2'h0;
         delay_q     <= ehpc_pkg::RST_DELAY;
         mode_q      <= ehpc_pkg::RST_MODE;
         term_ovr_q  <= 1'b0;
         manual_q    <= 1'b0;
         no_auto_q   <= 1'b0;
         reboot_q    <= 1'b0;
      end else begin
         reboot_q <= wr_link && req.addr == ehpc_pkg::OFS_REBOOT &&
                     req.wdata[ehpc_pkg::BIT_REBOOT];
         if (wr_io && req.addr == ehpc_pkg::OFS_HPD_PIN) begin
            man_level_q <= {req.wdata[ehpc_pkg::BIT_MAN_B],
                            req.wdata[ehpc_pkg::BIT_MAN_A]};
            float_q     <= {req.wdata[ehpc_pkg::BIT_FLOAT_B],
                            req.wdata[ehpc_pkg::BIT_FLOAT_A]};
         end
         if (wr_link && req.addr == ehpc_pkg::OFS_HPD_CTL) begin
            delay_q    <= req.wdata[ehpc_pkg::BIT_DELAY +: 4];
            term_ovr_q <= req.wdata[ehpc_pkg::BIT_TERM];
            mode_q     <= req.wdata[ehpc_pkg::BIT_MODE +: 2];
            manual_q   <= req.wdata[ehpc_pkg::BIT_MANUAL];
         end
         if (wr_rept && req.addr == ehpc_pkg::OFS_WAKE) begin
            no_auto_q <= req.wdata[ehpc_pkg::BIT_NOAUTO];
         end
      end
   end

   // enables; wake from mode 0 re-enables both, ram left untouched
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         en_q   <= 2'h0;
         en_p_q <= 2'h0;
         pd_p_q <= 1'b0;
      end else begin
         pd_p_q <= pd_mode0;
         en_p_q <= en_q;
         if (wake) begin
            en_q <= 2'h3;
         end else if (wr_rept && req.addr == ehpc_pkg::OFS_ID_EN) begin
            en_q <= req.wdata[ehpc_pkg::BIT_EN +: 2];
         end
      end
   end

   // controller is never gated by the power-down modes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cst_q   <= C_CLEAR;
         caddr_q <= 9'h000;
         sum_q   <= 8'h00;
         batch_q <= 2'h0;
      end else if (reboot_q) begin
         cst_q   <= C_CLEAR;
         caddr_q <= 9'h000;
      end else begin
         case (cst_q)
            C_CLEAR: begin
               caddr_q <= caddr_q + 9'h001;
               if (caddr_q == ehpc_pkg::RAM_LAST) begin
                  cst_q <= C_IDLE;
               end
            end
            C_IDLE: begin
               if (pend_q != 2'h0) begin
                  cst_q   <= C_SUM;
                  caddr_q <= 9'h000;
                  sum_q   <= 8'h00;
                  batch_q <= pend_q;
               end
            end
            C_SUM: begin
               caddr_q <= caddr_q + 9'h001;
               if (caddr_q[6:0] == ehpc_pkg::CKSUM_POS) begin
                  sum_q <= 8'h00;
               end else begin
                  sum_q <= sum_q + ram[caddr_q];
               end
               if (sweep_end) begin
                  cst_q <= C_IDLE;
               end
            end
            default: cst_q <= C_IDLE;
         endcase
      end
   end

   // ports become active only when their checksum sweep ends
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_q <= 2'h0;
         act_q  <= 2'h0;
      end else if (reboot_q || cst_q == C_CLEAR) begin
         pend_q <= en_q;
         act_q  <= 2'h0;
      end else begin
         pend_q <= ((pend_q & ~((cst_q == C_IDLE) ? pend_q : 2'h0)) |
                   (en_q & ~en_p_q)) & en_q;
         act_q  <= (act_q | (sweep_end ? batch_q : 2'h0)) & en_q;
      end
   end

   always_ff @(posedge clk) begin
      if (ctrl_we) begin
         ram[caddr_q] <= ctrl_wdata;
      end else if (host_we) begin
         ram[req.addr] <= req.wdata;
      end
   end

   always_comb begin
      rd_val = 8'h00;
      case (req.map)
         ehpc_pkg::EHPC_MAP_IO: begin
            if (req.addr == ehpc_pkg::OFS_HPD_PIN) begin
               rd_val[ehpc_pkg::BIT_MAN_A]   = man_level_q[0];
               rd_val[ehpc_pkg::BIT_MAN_B]   = man_level_q[1];
               rd_val[ehpc_pkg::BIT_FLOAT_A] = float_q[0];
               rd_val[ehpc_pkg::BIT_FLOAT_B] = float_q[1];
            end else if (req.addr == ehpc_pkg::OFS_HPD_STAT) begin
               rd_val[ehpc_pkg::BIT_DRV_A] = status[0];
               rd_val[ehpc_pkg::BIT_DRV_B] = status[1];
            end
         end
         ehpc_pkg::EHPC_MAP_LINK: begin
            if (req.addr == ehpc_pkg::OFS_HPD_CTL) begin
               rd_val = {delay_q, term_ovr_q, mode_q, manual_q};
            end
         end
         ehpc_pkg::EHPC_MAP_REPT: begin
            if (req.addr == ehpc_pkg::OFS_ID_EN) begin
               rd_val[ehpc_pkg::BIT_EN +: 2] = en_q;
            end else if (req.addr == ehpc_pkg::OFS_ID_FLAG) begin
               rd_val[1:0] = act_q;
            end else if (req.addr == ehpc_pkg::OFS_WAKE) begin
               rd_val[ehpc_pkg::BIT_NOAUTO] = no_auto_q;
            end
         end
         default: rd_val = ram[req.addr];
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rsp_valid_q <= 1'b0;
         rsp_data_q  <= 8'h00;
      end else begin
         rsp_valid_q <= req_valid;
         rsp_data_q  <= (req_valid && !req.we) ? rd_val : 8'h00;
      end
   end

   // cable detect delay, one 100 ms step per tick
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cab_m_q <= 2'h0;
         cab_q   <= 2'h0;
         dly_q   <= 2'h0;
         for (int i = 0; i < 2; i++) begin
            step_q[i] <= '0;
            tick_q[i] <= 4'h0;
         end
      end else begin
         cab_m_q <= cable_det;
         cab_q   <= cab_m_q;
         for (int i = 0; i < 2; i++) begin
            if (!cab_q[i]) begin
               dly_q[i]  <= 1'b0;
               step_q[i] <= '0;
               tick_q[i] <= 4'h0;
            end else if (!dly_q[i]) begin
               if (tick_q[i] >= delay_q) begin
                  dly_q[i] <= 1'b1;
               end else if (step_q[i] == STEP_W'(STEP_CYCLES - 1)) begin
                  step_q[i] <= '0;
                  tick_q[i] <= tick_q[i] + 4'h1;
               end else begin
                  step_q[i] <= step_q[i] + STEP_W'(1);
               end
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         case (mode_q)
            2'h0: hpa_d[i] = act_q[i];
            2'h1: hpa_d[i] = dly_q[i];
            2'h2: hpa_d[i] = act_q[i] & dly_q[i];
            default: hpa_d[i] = act_q[i] & dly_q[i] & man_level_q[i];
         endcase
         if (manual_q) begin
            hpa_d[i] = man_level_q[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hpa_q <= 2'h0;
      end else begin
         hpa_q <= hpa_d;
      end
   end

   for (genvar p = 0; p < 2; p++) begin : g_ddc
      ehpc_ddc_slave u_ddc (
         .clk     (clk),
         .rst_b   (rst_b),
         .scl_pin (ddc_scl[p]),
         .sda_pin (ddc_sda_in[p]),
         .enabled (act_q[p]),
         .rd_data (ram[ddc_addr[p]]),
         .rd_addr (ddc_addr[p]),
         .sda_out (ddc_sda_out[p]),
         .sda_oe  (ddc_sda_oe[p])
      );
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   float_release_a: assert property (wr_io &&
      req.addr == ehpc_pkg::OFS_HPD_PIN && req.wdata[3] |=> !hpd_oe[0])
      else $error("float bit did not release pin");
   status_read_a: assert property (req_valid && !req.we &&
      req.map == ehpc_pkg::EHPC_MAP_IO && req.addr == ehpc_pkg::OFS_HPD_STAT
      |=> rsp_data_q[3] == $past(hpd_out[0] & hpd_oe[0]))
      else $error("hot plug status readback wrong");
   term_follow_a: assert property (term_ovr_q |->
      term_en == (hpd_out & hpd_oe))
      else $error("termination not following hot plug");
   reboot_clear_a: assert property (wr_link &&
      req.addr == ehpc_pkg::OFS_REBOOT && req.wdata[3] |=> ##1
      key_vector_clear && act_q == 2'h0)
      else $error("reboot did not start clearing");
   clear_bound_a: assert property (key_vector_clear && caddr_q == 9'h000
      && !reboot_q |-> ##[511:513] !key_vector_clear)
      else $error("ram clear too slow");
   en_gate_a: assert property (!en_q[0] |=> !act_q[0])
      else $error("port active without enable");
   sum_first_a: assert property ($rose(act_q[0]) |->
      $past(sweep_end))
      else $error("port active before checksums");
   flag_read_a: assert property (req_valid && !req.we &&
      req.map == ehpc_pkg::EHPC_MAP_REPT &&
      req.addr == ehpc_pkg::OFS_ID_FLAG |=> rsp_data_q[1:0] == $past(act_q))
      else $error("active flags readback wrong");
   cksum_store_a: assert property (cst_q == C_SUM && caddr_q == 9'h07F
      |=> ram[9'h07F] == $past(8'h00 - sum_q))
      else $error("checksum byte wrong");
   wake_auto_a: assert property ($fell(pd_mode0) && !no_auto_q
      |=> en_q == 2'h3)
      else $error("no auto enable on wake");
   manual_level_a: assert property (manual_q && $past(manual_q) |->
      hpd_out == $past(man_level_q))
      else $error("manual level not followed");
   unplug_drop_a: assert property (!manual_q && mode_q == 2'h1 &&
      !cab_q[0] |=> ##1 !hpd_out[0])
      else $error("hot plug held after unplug");
   zero_delay_a: assert property (!manual_q && mode_q == 2'h1 &&
      delay_q == 4'h0 && cab_q[0] [*3] |-> hpd_out[0])
      else $error("zero delay not immediate");

   sweep_done_c: cover property (sweep_end && batch_q == 2'h3);
   ddc_ack_c: cover property (ddc_sda_oe[0] && act_q[0]);
   wake_c: cover property (wake);
   hpd_rise_c: cover property ($rose(hpd_out[1]));
endmodule

// File: ehpc_ddc_src.sv
// source model reading identification data over one ddc link
`timescale 1ns/1ns
module ehpc_ddc_src (
   input  wire logic sda,
   output logic      scl,
   output logic      pull
);
   logic r;
   initial begin
      scl  = 1'b1;
      pull = 1'b0;
   end
   // one bit per 400 ns, data moved mid low phase
   task automatic bit_io(input logic b, output logic v);
      #100 pull = ~b;
      #100 scl = 1'b1;
      #100 v = sda;
      #100 scl = 1'b0;
   endtask
   task automatic start();
      #100 pull = 1'b0;
      #100 scl = 1'b1;
      #100 pull = 1'b1;
      #100 scl = 1'b0;
   endtask
   task automatic stop();
      #100 pull = 1'b1;
      #100 scl = 1'b1;
      #100 pull = 1'b0;
      #100;
   endtask
   task automatic wb(input logic [7:0] x, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(x[i], r);
      bit_io(1'b1, ack);
   endtask
   task automatic rb(input logic last, output logic [7:0] x);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, x[i]);
      bit_io(last, r);
   endtask
endmodule

// File: tb_ehpc_top.sv
// bench for the identification ram and hot plug block
`timescale 1ns/1ns
module tb_ehpc_top;
   logic                clk, rst_b, req_valid, rsp_valid_q;
   ehpc_pkg::ehpc_req_t req;
   logic [7:0]          rsp_data_q, d, s;
   logic                pd_mode0, kvc, k;
   logic [1:0]          cable_det, term_en, hpd_out, hpd_oe;
   logic [1:0]          scl, pull, sda_oe, sdo;
   int                  n_fail, n_tests;
   wire  [1:0]          sda = ~(pull | sda_oe);

   ehpc_top #(.STEP_CYCLES(20)) dut_u (
      .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
      .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
      .pd_mode0(pd_mode0), .cable_det(cable_det), .term_ctrl(2'h2),
      .term_en(term_en), .hpd_out(hpd_out), .hpd_oe(hpd_oe),
      .ddc_scl(scl), .ddc_sda_in(sda), .ddc_sda_out(sdo),
      .ddc_sda_oe(sda_oe), .key_vector_clear(kvc));
   ehpc_ddc_src src_a (.sda(sda[0]), .scl(scl[0]), .pull(pull[0]));
   ehpc_ddc_src src_b (.sda(sda[1]), .scl(scl[1]), .pull(pull[1]));

   function automatic logic [7:0] pat(input logic [8:0] a);
      return 8'(a * 5 + 3);
   endfunction
   task automatic give_verdict();
      if (n_fail == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic acc(input logic we, input logic [1:0] m,
                      input logic [8:0] a, input logic [7:0] v);
      req_valid = 1'b1;
      req = '{we, ehpc_pkg::ehpc_map_t'(m), a, v};
      @(posedge clk) #1 req_valid = 1'b0;
      if (rsp_valid_q !== 1'b1) @(posedge clk) #1;
      d = rsp_data_q;
      idle(1);
   endtask
   task automatic poll(input logic [8:0] a, input logic [7:0] e);
      d = ~e;
      for (int i = 0; i < 400 && d !== e; i++) acc(1'b0, 2'h2, a, 8'h00);
      chk(d, e);
      if (d !== e) give_verdict();
   endtask
   task automatic hw(input logic [1:0] e, input int n);
      for (int i = 0; i < n && hpd_out !== e; i++) idle(1);
      chk(8'(hpd_out), 8'(e));
      if (hpd_out !== e) give_verdict();
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      logic [18:0] t [8] = '{19'h020C0, 19'h02100, 19'h25A00, 19'h26CA2,
                             19'h47400, 19'h47600, 19'h47A00, 19'h5F000};
      n_fail = 0;
      n_tests = 0;
      rst_b = 1'b0;
      req_valid = 1'b0;
      req = '0;
      pd_mode0 = 1'b0;
      cable_det = 2'h0;
      idle(16);
      rst_b = 1'b1;
      foreach (t[i]) begin
         acc(1'b0, t[i][18:17], t[i][16:8], 8'h00);
         chk(d, t[i][7:0]);
      end
      acc(1'b1, 2'h2, 9'h076, 8'hFF);
      acc(1'b0, 2'h2, 9'h076, 8'h00);
      chk(d, 8'h00);
      idle(20000);
      acc(1'b0, 2'h3, 9'h005, 8'h00);
      chk(d, 8'h00);
      for (int a = 0; a < 512; a++) acc(1'b1, 2'h3, 9'(a), pat(9'(a)));
      src_a.start();
      src_a.wb(8'hA0, k);
      src_a.stop();
      chk(8'(k), 8'h01);
      acc(1'b1, 2'h2, 9'h074, 8'h03);
      acc(1'b0, 2'h2, 9'h076, 8'h00);
      chk(d, 8'h00);
      poll(9'h076, 8'h03);
      for (int b = 0; b < 4; b++) begin
         s = 8'h00;
         for (int i = 0; i < 127; i++) s = s + pat(9'(b * 128 + i));
         acc(1'b0, 2'h3, 9'(b * 128 + 127), 8'h00);
         chk(d, 8'h00 - s);
      end
      src_a.start();
      src_a.wb(8'hA0, k);
      src_a.wb(8'h00, k);
      src_a.wb(8'h55, k);
      src_a.stop();
      chk(8'(k), 8'h01);
      acc(1'b0, 2'h3, 9'h000, 8'h00);
      chk(d, pat(9'h000));
      pd_mode0 = 1'b1;
      src_b.start();
      src_b.wb(ehpc_pkg::DDC_SEG_WR, k);
      src_b.wb(8'h01, k);
      src_b.start();
      src_b.wb(ehpc_pkg::DDC_EDID_WR, k);
      src_b.wb(8'h10, k);
      src_b.start();
      src_b.wb(8'hA1, k);
      chk(8'(k), 8'h00);
      chk(8'(sdo), 8'h00);
      src_b.rb(1'b0, d);
      chk(d, pat(9'h110));
      src_b.rb(1'b1, d);
      src_b.stop();
      chk(d, pat(9'h111));
      src_b.start();
      src_b.wb(8'hA1, k);
      src_b.rb(1'b1, d);
      src_b.stop();
      chk(d, pat(9'h012));
      acc(1'b1, 2'h2, 9'h074, 8'h00);
      poll(9'h076, 8'h00);
      pd_mode0 = 1'b0;
      poll(9'h076, 8'h03);
      acc(1'b0, 2'h3, 9'h012, 8'h00);
      chk(d, pat(9'h012));
      acc(1'b1, 2'h2, 9'h07A, 8'h02);
      acc(1'b1, 2'h2, 9'h074, 8'h00);
      pd_mode0 = 1'b1;
      idle(4);
      pd_mode0 = 1'b0;
      idle(600);
      acc(1'b0, 2'h2, 9'h076, 8'h00);
      chk(d, 8'h00);
      acc(1'b1, 2'h1, 9'h06C, 8'h22);
      chk(8'(term_en), 8'h02);
      cable_det = 2'h1;
      idle(36);
      chk(8'(hpd_out), 8'h00);
      hw(2'h1, 20);
      acc(1'b0, 2'h0, 9'h021, 8'h00);
      chk(d, 8'h08);
      acc(1'b1, 2'h1, 9'h06C, 8'h2A);
      chk(8'(term_en), 8'h01);
      acc(1'b1, 2'h0, 9'h020, 8'hC8);
      chk(8'(hpd_oe), 8'h02);
      acc(1'b0, 2'h0, 9'h021, 8'h00);
      chk(d, 8'h00);
      acc(1'b1, 2'h0, 9'h020, 8'h40);
      acc(1'b1, 2'h1, 9'h06C, 8'h01);
      hw(2'h2, 8);
      acc(1'b1, 2'h1, 9'h06C, 8'h02);
      cable_det = 2'h0;
      hw(2'h0, 8);
      cable_det = 2'h1;
      hw(2'h1, 8);
      acc(1'b1, 2'h1, 9'h06C, 8'h04);
      hw(2'h0, 8);
      acc(1'b1, 2'h1, 9'h05A, 8'h08);
      idle(2);
      chk(8'(kvc), 8'h01);
      acc(1'b0, 2'h1, 9'h05A, 8'h00);
      chk(d, 8'h00);
      idle(600);
      acc(1'b0, 2'h3, 9'h012, 8'h00);
      chk(d, 8'h00);
      give_verdict();
   end
endmodule
